/* rtl/psrg_regs.vh */
// psrg_regs.vh: timing constants of the supervisor and ram guard
// assumes ref_clk at 40 MHz; included by its bare name
`ifndef PSRG_REGS_VH
`define PSRG_REGS_VH

// ****************************************
// clock and times
// ****************************************
`define PSRG_CLK_HZ          40000000
`define PSRG_RESET_HOLD_MS   250
`define PSRG_DEBOUNCE_MS     10
`define PSRG_WATCHDOG_MS     1000
// cycle counts derived from the times (least times, exact here)
`define PSRG_RESET_HOLD_CYC  ((`PSRG_CLK_HZ / 1000) * `PSRG_RESET_HOLD_MS)
`define PSRG_DEBOUNCE_CYC    ((`PSRG_CLK_HZ / 1000) * `PSRG_DEBOUNCE_MS)
`define PSRG_WATCHDOG_CYC    ((`PSRG_CLK_HZ / 1000) * `PSRG_WATCHDOG_MS)
`define PSRG_CNT_W           32

// ****************************************
// reset value and state encodings
// ****************************************
`define PSRG_HOLD_RST        32'h00000000
`define PSRG_ST_IDLE         2'h0
`define PSRG_ST_HOLD         2'h1
`define PSRG_ST_WAIT_REL     2'h2

`endif

/* rtl/psrg_supervisor.v */
// psrg_supervisor.v: processor reset supervisor and sram chip-enable guard
// assumes all inputs synchronous to ref_clk; power_fail comes from an
// analog comparator; the reset pin is open drain with an external pullup
//
// Operation
// - reset driven active while power-fail indication is asserted
// - reset held a further 250 ms after supply returns
// - debounced pushbutton press gives reset pulse of at least 250 ms
// - missing watchdog strobe before timeout forces reset active
// - both sram selects inactive while ram enable input is high
// - both sram selects inactive during supply power transients
// - low-byte select only while low-byte enable and ram enable low
// - high-byte select only while high-byte enable and ram enable low
// - reset pin doubles as pushbutton input, driven open drain only
// - watchdog strobe input only services the watchdog timer
`timescale 1ns/10ps
`default_nettype none
`include "psrg_regs.vh"

module psrg_supervisor #(
  parameter [31:0] RESET_HOLD_CYC = `PSRG_RESET_HOLD_CYC,
  parameter [31:0] DEBOUNCE_CYC   = `PSRG_DEBOUNCE_CYC,
  parameter [31:0] WATCHDOG_CYC   = `PSRG_WATCHDOG_CYC
) (
  input  wire ref_clk,
  input  wire arst_n,
  input  wire power_fail,
  input  wire watchdog_strobe_n,
  input  wire ram_enable_in_n,
  input  wire low_byte_enable_n,
  input  wire high_byte_enable_n,
  input  wire cpu_reset_in,
  output wire cpu_reset_out,
  output wire cpu_reset_oe,
  output reg  sram_low_byte_select_n,
  output reg  sram_high_byte_select_n,
  output wire reset_active
);

  // ****************************************
  // state
  // ****************************************
  localparam [1:0] ST_IDLE     = `PSRG_ST_IDLE;
  localparam [1:0] ST_HOLD     = `PSRG_ST_HOLD;
  localparam [1:0] ST_WAIT_REL = `PSRG_ST_WAIT_REL;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [31:0] hold_reg;
  reg  [31:0] hold_next;
  reg  [31:0] deb_reg;
  reg  [31:0] wdog_reg;
  reg         press_reg;
  reg         strobe_prev_reg;
  wire        strobe_fall;
  wire        wdog_expired;
  wire        pin_low_ext;

  // the pin reads low from outside only when we are not pulling it
  assign pin_low_ext = ~cpu_reset_in & (state_reg == ST_IDLE);
  assign strobe_fall = strobe_prev_reg & ~watchdog_strobe_n;
  assign wdog_expired = (wdog_reg >= WATCHDOG_CYC - 32'h00000001);

  // debounce of the reset pin sensed as a pushbutton
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      deb_reg   <= `PSRG_HOLD_RST;
      press_reg <= 1'b0;
    end else begin
      press_reg <= 1'b0;
      if (!pin_low_ext) begin
        deb_reg <= `PSRG_HOLD_RST;
      end else if (deb_reg >= DEBOUNCE_CYC - 32'h00000001) begin
        press_reg <= 1'b1;
        deb_reg   <= `PSRG_HOLD_RST;
      end else begin
        deb_reg <= deb_reg + 32'h00000001;
      end
    end
  end

  // watchdog: strobe falls or reset end restart it, held at zero outside ST_IDLE
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdog_reg        <= `PSRG_HOLD_RST;
      strobe_prev_reg <= 1'b1;
    end else begin
      strobe_prev_reg <= watchdog_strobe_n;
      if (state_reg != ST_IDLE || strobe_fall) begin
        wdog_reg <= `PSRG_HOLD_RST;
      end else if (!wdog_expired) begin
        wdog_reg <= wdog_reg + 32'h00000001;
      end
    end
  end

  // reset sequencer
  always @* begin
    state_next = state_reg;
    hold_next  = hold_reg;
    case (state_reg)
      ST_IDLE: begin
        if (power_fail || press_reg || wdog_expired) begin
          state_next = ST_HOLD;
          hold_next  = `PSRG_HOLD_RST;
        end
      end
      ST_HOLD: begin
        if (power_fail) begin
          hold_next = `PSRG_HOLD_RST;
        end else if (hold_reg >= RESET_HOLD_CYC - 32'h00000001) begin
          state_next = ST_WAIT_REL;
        end else begin
          hold_next = hold_reg + 32'h00000001;
        end
      end
      ST_WAIT_REL: begin
        // let the pullup raise the pin before sensing it again
        if (power_fail) begin
          state_next = ST_HOLD;
          hold_next  = `PSRG_HOLD_RST;
        end else if (cpu_reset_in) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_HOLD;
        hold_next  = `PSRG_HOLD_RST;
      end
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_HOLD;
      hold_reg  <= `PSRG_HOLD_RST;
    end else begin
      state_reg <= state_next;
      hold_reg  <= hold_next;
    end
  end

  // open drain: drive low, enable low while driving
  assign reset_active  = (state_reg == ST_HOLD);
  assign cpu_reset_out = 1'b0;
  assign cpu_reset_oe  = ~reset_active;

  // sram chip-enable gating
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sram_low_byte_select_n  <= 1'b1;
      sram_high_byte_select_n <= 1'b1;
    end else begin
      sram_low_byte_select_n  <= power_fail | ram_enable_in_n |
                                 low_byte_enable_n;
      sram_high_byte_select_n <= power_fail | ram_enable_in_n |
                                 high_byte_enable_n;
    end
  end

endmodule
`default_nettype wire

/* testbench/psrg_monitor.sv */
// port checker of the supervisor, bound into psrg_supervisor
// assumes all ports synchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none
module psrg_monitor #(parameter int RESET_HOLD_CYC = 20) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic power_fail,
  input wire logic ram_enable_in_n,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  input wire logic cpu_reset_out,
  input wire logic cpu_reset_oe,
  input wire logic sram_low_byte_select_n,
  input wire logic sram_high_byte_select_n
);
  localparam int HM = RESET_HOLD_CYC - 1;
  // byte requests that may open the sram
  wire lo = !low_byte_enable_n && !ram_enable_in_n && !power_fail;
  wire hi = !high_byte_enable_n && !ram_enable_in_n && !power_fail;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_fail_reset: assert property (power_fail |=> !cpu_reset_oe)
    else $error("reset not driven in power fail");
  a_hold_len: assert property ($fell(power_fail) |->
    ##HM !cpu_reset_oe ##[1:4] cpu_reset_oe) else $error("bad hold");
  a_fail_guard: assert property (power_fail |=>
    sram_low_byte_select_n && sram_high_byte_select_n) else $error("guard");
  a_low_only: assert property (!sram_low_byte_select_n |-> $past(lo))
    else $error("low select without request");
  a_high_only: assert property (!sram_high_byte_select_n |-> $past(hi))
    else $error("high select without request");
  a_low_on: assert property (lo |=> !sram_low_byte_select_n)
    else $error("low select missing");
  a_high_on: assert property (hi |=> !sram_high_byte_select_n)
    else $error("high select missing");
  a_drain_only: assert property (!cpu_reset_out)
    else $error("reset data not low");
endmodule
bind psrg_supervisor psrg_monitor #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) u_mon (
  .ref_clk, .arst_n, .power_fail, .ram_enable_in_n, .low_byte_enable_n,
  .high_byte_enable_n, .cpu_reset_out, .cpu_reset_oe,
  .sram_low_byte_select_n, .sram_high_byte_select_n);
`default_nettype wire

/* testbench/psrg_host_model.sv */
// reset pin with pullup, our open drain and the pushbutton
`timescale 1ns/10ps
`default_nettype none
module psrg_host_model (
  input  wire logic cpu_reset_oe,
  input  wire logic press,
  output wire logic pin
);
  // low when the dut or the button pulls, else pulled high
  assign pin = cpu_reset_oe && !press;
endmodule
`default_nettype wire

/* testbench/psrg_supervisor_tb.sv */
// bench: sram guard, power fail, button and watchdog resets
// assumes small timing parameters on the dut
`timescale 1ns/10ps
`default_nettype none
module psrg_supervisor_tb;
  localparam int H = 20;
  logic ref_clk = 0, arst_n = 0, power_fail = 0, st_n = 1, kick = 1;
  logic ram_n = 1, low_n = 1, high_n = 1, press = 0;
  wire  pin, oe, sel_l, sel_h;
  int   n_fail = 0, checks = 0, n;
  psrg_supervisor #(.RESET_HOLD_CYC(H), .DEBOUNCE_CYC(4), .WATCHDOG_CYC(50))
    u_dut (.ref_clk, .arst_n, .power_fail, .watchdog_strobe_n(st_n),
    .ram_enable_in_n(ram_n), .low_byte_enable_n(low_n),
    .high_byte_enable_n(high_n), .cpu_reset_in(pin), .cpu_reset_out(),
    .cpu_reset_oe(oe), .sram_low_byte_select_n(sel_l),
    .sram_high_byte_select_n(sel_h), .reset_active());
  psrg_host_model u_host (.cpu_reset_oe(oe), .press, .pin);
  initial forever #12.5 ref_clk = ~ref_clk;
  // strobe falls every second cycle while kick is set
  always @(negedge ref_clk) if (kick) st_n <= ~st_n;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  // waits up to lim cycles for a reset, then counts its length in n
  task rst_len(input int lim);
    n = 0;
    while (oe !== 1'h0 && lim-- > 0) cyc(1);
    while (oe === 1'h0 && n < 200) begin
      cyc(1);
      n++;
    end
  endtask
  task t_sram;
    for (int i = 0; i < 8; i++) begin
      {ram_n, low_n, high_n} = i[2:0];
      cyc(2);
      chk(sel_l, ram_n | low_n);
      chk(sel_h, ram_n | high_n);
    end
  endtask
  task t_power;
    {ram_n, low_n, high_n} = 3'h0;
    power_fail = 1;
    cyc(2);
    chk(oe, 1'h0);
    chk({sel_l, sel_h}, 2'h3);
    power_fail = 0;
    rst_len(1);
    chk(n >= H, 1'h1);
  endtask
  task t_button;
    press = 1;
    cyc(2);
    press = 0;
    cyc(10);
    chk(oe, 1'h1);
    press = 1;
    cyc(5);
    press = 0;
    rst_len(5);
    chk(n >= H, 1'h1);
  endtask
  task t_wdog;
    kick = 0;
    cyc(40);
    chk(oe, 1'h1);
    rst_len(30);
    chk(n >= H, 1'h1);
    kick = 1;
  endtask
  task report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(3);
    arst_n = 1;
    rst_len(5);
    t_sram;
    t_power;
    t_button;
    t_wdog;
    report_and_stop;
  end
  // cuts a hang short
  initial begin
    #20us;
    n_fail++;
    report_and_stop;
  end
endmodule
`default_nettype wire
